// ### spe_pkg.sv
// Shared constants and decoders for the serial programming entry link
package spe_pkg;
	localparam int          CLK_PERIOD_NS  = 40;
	localparam int          WORD_BITS      = 16;
	localparam int          KEY_BITS       = 32;
	// Entry key value is arbitrary
	localparam logic [31:0] KEY_VALUE      = 32'h5A3C_96E1;
	// Transfer frame: two op bits, one turnaround bit, sixteen data bits
	localparam logic [5:0]  OP_LAST        = 6'h01;
	localparam logic [5:0]  TURN_CNT       = 6'h02;
	localparam logic [5:0]  XFER_LAST      = 6'h12;
	localparam logic [5:0]  KEY_LAST       = 6'h1F;
	// Three edges: two to sync the pins, one to change state, so a frame starts aligned
	localparam logic [5:0]  DUMMY_LAST     = 6'h02;
	localparam logic [1:0]  OP_CLEAR       = 2'h0;
	localparam logic [1:0]  OP_WRITE       = 2'h1;
	localparam logic [1:0]  OP_READ        = 2'h2;
	localparam logic [1:0]  OP_STATUS      = 2'h3;
	localparam int          FIFO_DEPTH     = 32;
	// Serial clock half period in clk_in cycles, minus one
	localparam logic [2:0]  SCLK_HALF_LAST = 3'h3;
	localparam int          SETTLE_NS      = 320;
	localparam int          SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0]  SETTLE_LAST    = 6'(SETTLE_CYC - 1);

	// Ops whose data phase is driven by the device
	function automatic logic op_device_drives(input logic [1:0] op);
		return (op == OP_READ) || (op == OP_STATUS);
	endfunction
endpackage

// ### spe_link_if.sv
// Pin bundle between programmer and device, with data line resolution
`timescale 1ns/1ps
interface spe_link_if;
	logic prog_serial_clock;
	logic master_clear_low;
	logic master_clear_high;
	logic host_data;
	logic host_data_oe_n;
	logic dev_data;
	logic dev_data_oe_n;
	logic prog_serial_data;

	// Weak pull-up when nobody drives
	assign prog_serial_data = !host_data_oe_n ? host_data :
		(!dev_data_oe_n ? dev_data : 1'b1);

	modport host (
		output prog_serial_clock,
		output master_clear_low,
		output master_clear_high,
		output host_data,
		output host_data_oe_n,
		input  prog_serial_data
	);
	modport dev (
		input  prog_serial_clock,
		input  master_clear_low,
		input  master_clear_high,
		output dev_data,
		output dev_data_oe_n,
		input  prog_serial_data
	);
endinterface

// ### spe_fifo.sv
// Single clock FIFO with valid/ready on both sides
`timescale 1ns/1ps
module spe_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	// Fill side
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	// Drain side
	output logic                  out_valid_out,
	output logic [WIDTH-1:0]      out_data_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic [AW:0]      next_wr_ptr;
	logic [AW:0]      next_rd_ptr;
	logic             push;
	logic             pop;

	assign in_ready_out  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
	assign out_valid_out = wr_ptr != rd_ptr;
	assign out_data_out  = mem[rd_ptr[AW-1:0]];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	always_comb begin
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data_in;
		end
	end
endmodule // spe_fifo

// ### spe_device.sv
// Device end: programming mode entry, key check and word transfer
// Functional notes
// - Programmer holds clock, data low raising high
// - Key entry accepted only with enable bit set
// - Enable bit zero: key sequences are ignored
// - Master clear low, then 32-bit key shifted
// - Low-voltage session lasts while master clear low
// - Enable bit set forces master clear reset
// - Enable bit cleared only in high-voltage session
// - Data pin bidirectional, clock driven by programmer
// - Session writes and verifies words over link
`timescale 1ns/1ps
module spe_device (
	// Link pins
	spe_link_if.dev     link,
	// Device clock and reset
	input  wire logic   clk_in,
	input  wire logic   reset_in,
	// Configuration
	input  wire logic   low_voltage_entry_enable_in,
	input  wire logic   master_clear_reset_cfg_in,
	// Memory write port
	output logic        mem_write_valid_out,
	output logic [15:0] mem_write_data_out,
	input  wire logic   mem_write_ready_in,
	// Status
	output logic        program_mode_out,
	output logic        hv_session_out,
	output logic        low_voltage_clear_out,
	output logic        master_clear_reset_enable_out
);
	typedef enum logic [2:0] {
		SD_IDLE = 3'b001,
		SD_KEY  = 3'b010,
		SD_OP   = 3'b100
	} spe_dev_state_e;

	// Link domain state
	spe_dev_state_e state;
	spe_dev_state_e next_state;
	logic [31:0]    key_sr;
	logic [31:0]    next_key_sr;
	logic [5:0]     bit_cnt;
	logic [5:0]     next_bit_cnt;
	logic [1:0]     op;
	logic [1:0]     next_op;
	logic [15:0]    shreg;
	logic [15:0]    next_shreg;
	logic [15:0]    word_hold;
	logic [15:0]    next_word_hold;
	logic [15:0]    drive_sr;
	logic [15:0]    next_drive_sr;
	logic           drive_en;
	logic           next_drive_en;
	logic           req_tgl;
	logic           next_req_tgl;
	logic           clr_tgl;
	logic           next_clr_tgl;
	logic           hv_mode;
	logic           next_hv_mode;
	logic           session;
	logic           next_session;
	logic           pending;
	// Link domain synchronisers
	logic           mcl_low_m;
	logic           mcl_low_s;
	logic           hv_pin_m;
	logic           hv_pin_s;
	logic           hv_ok_m;
	logic           hv_ok_s;
	logic           lvp_m;
	logic           lvp_s;
	logic           ack_m;
	logic           ack_s;
	// Device clock domain
	logic           sclk_m;
	logic           sclk_s;
	logic           dat_m;
	logic           dat_s;
	logic           hvp_m;
	logic           hvp_s;
	logic           mlp_m;
	logic           mlp_s;
	logic           req_m;
	logic           req_s;
	logic           clr_m;
	logic           clr_s;
	logic           prog_m;
	logic           prog_s;
	logic           hv_prev;
	logic           hv_session;
	logic           next_hv_session;
	logic           req_d;
	logic           clr_d;
	logic           ack_tgl;
	logic           next_ack_tgl;
	logic           mem_valid;
	logic           next_mem_valid;
	logic [15:0]    mem_word;
	logic [15:0]    next_mem_word;
	logic           lv_clear;
	logic           mrst_en;

	assign pending            = req_tgl != ack_s;
	assign link.dev_data      = drive_sr[0];
	assign link.dev_data_oe_n = !drive_en;

	always_ff @(posedge link.prog_serial_clock) begin
		mcl_low_m <= link.master_clear_low;
		mcl_low_s <= mcl_low_m;
		hv_pin_m  <= link.master_clear_high;
		hv_pin_s  <= hv_pin_m;
		hv_ok_m   <= hv_session;
		hv_ok_s   <= hv_ok_m;
		lvp_m     <= low_voltage_entry_enable_in;
		lvp_s     <= lvp_m;
		ack_m     <= ack_tgl;
		ack_s     <= ack_m;
	end

	always_comb begin
		next_state     = state;
		next_key_sr    = key_sr;
		next_bit_cnt   = bit_cnt;
		next_op        = op;
		next_shreg     = shreg;
		next_word_hold = word_hold;
		next_drive_sr  = drive_sr;
		next_drive_en  = drive_en;
		next_req_tgl   = req_tgl;
		next_clr_tgl   = clr_tgl;
		next_hv_mode   = hv_mode;
		// Pin released: the whole link side returns to idle
		if (!mcl_low_s && !hv_pin_s) begin
			next_state    = SD_IDLE;
			next_bit_cnt  = 6'h00;
			next_hv_mode  = 1'b0;
			next_drive_en = 1'b0;
			next_key_sr   = 32'h0000_0000;
			// Link side has no reset: toggles settle here, a write in flight is lost
			next_req_tgl  = ack_s;
			next_clr_tgl  = 1'b0;
		end else begin
			unique case (state)
				SD_IDLE: begin
					next_bit_cnt = 6'h00;
					if (hv_ok_s) begin
						next_state   = SD_OP;
						next_hv_mode = 1'b1;
					end else if (mcl_low_s && lvp_s) begin
						next_state = SD_KEY;
					end
				end
				SD_KEY: begin
					// Sliding window, so a bad attempt needs no restart
					next_key_sr = {link.prog_serial_data, key_sr[31:1]};
					if (!lvp_s) begin
						next_state = SD_IDLE;
					end else if (next_key_sr == spe_pkg::KEY_VALUE) begin
						next_state = SD_OP;
					end
				end
				SD_OP: begin
					if (hv_mode ? !hv_pin_s : !mcl_low_s) begin
						next_state    = SD_IDLE;
						next_drive_en = 1'b0;
						next_hv_mode  = 1'b0;
					end else begin
						next_bit_cnt = (bit_cnt == spe_pkg::XFER_LAST) ? 6'h00 : bit_cnt + 6'h01;
						if (bit_cnt <= spe_pkg::OP_LAST) begin
							next_op = {link.prog_serial_data, op[1]};
						end
						if (bit_cnt == spe_pkg::TURN_CNT) begin
							next_drive_en = spe_pkg::op_device_drives(op);
							next_drive_sr = (op == spe_pkg::OP_READ) ? word_hold :
								{15'h0, !pending};
							if (op == spe_pkg::OP_CLEAR && hv_mode) begin
								next_clr_tgl = !clr_tgl;
							end
						end
						if (bit_cnt > spe_pkg::TURN_CNT) begin
							next_shreg    = {link.prog_serial_data, shreg[15:1]};
							next_drive_sr = {1'b0, drive_sr[15:1]};
						end
						if (bit_cnt == spe_pkg::XFER_LAST) begin
							next_drive_en = 1'b0;
							// A write while one is still pending is dropped
							if (op == spe_pkg::OP_WRITE && !pending) begin
								next_word_hold = {link.prog_serial_data, shreg[15:1]};
								next_req_tgl   = !req_tgl;
							end
						end
					end
				end
			endcase
		end
		next_session = next_state == SD_OP;
	end

	always_ff @(posedge link.prog_serial_clock) begin
		state     <= next_state;
		key_sr    <= next_key_sr;
		bit_cnt   <= next_bit_cnt;
		op        <= next_op;
		shreg     <= next_shreg;
		word_hold <= next_word_hold;
		drive_sr  <= next_drive_sr;
		drive_en  <= next_drive_en;
		req_tgl   <= next_req_tgl;
		clr_tgl   <= next_clr_tgl;
		hv_mode   <= next_hv_mode;
		session   <= next_session;
	end

	always_ff @(posedge clk_in) begin
		sclk_m <= link.prog_serial_clock;
		sclk_s <= sclk_m;
		dat_m  <= link.prog_serial_data;
		dat_s  <= dat_m;
		hvp_m  <= link.master_clear_high;
		hvp_s  <= hvp_m;
		mlp_m  <= link.master_clear_low;
		mlp_s  <= mlp_m;
		req_m  <= req_tgl;
		req_s  <= req_m;
		clr_m  <= clr_tgl;
		clr_s  <= clr_m;
		prog_m <= session;
		prog_s <= prog_m;
	end

	always_comb begin
		// Entry only on a rising edge with clock and data quiet
		next_hv_session = hvp_s && (hv_session || (!hv_prev && !sclk_s && !dat_s));
		next_mem_valid  = mem_valid;
		next_mem_word   = mem_word;
		next_ack_tgl    = ack_tgl;
		if (req_s != req_d) begin
			next_mem_valid = 1'b1;
			next_mem_word  = word_hold;
		end else if (mem_valid && mem_write_ready_in) begin
			next_mem_valid = 1'b0;
			next_ack_tgl   = !ack_tgl;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			hv_prev    <= 1'b0;
			hv_session <= 1'b0;
			req_d      <= 1'b0;
			clr_d      <= 1'b0;
			ack_tgl    <= 1'b0;
			mem_valid  <= 1'b0;
			mem_word   <= 16'h0000;
			lv_clear   <= 1'b0;
			mrst_en    <= 1'b0;
		end else begin
			hv_prev    <= hvp_s;
			hv_session <= next_hv_session;
			req_d      <= req_s;
			clr_d      <= clr_s;
			ack_tgl    <= next_ack_tgl;
			mem_valid  <= next_mem_valid;
			mem_word   <= next_mem_word;
			lv_clear   <= (clr_s != clr_d) && hv_session;
			mrst_en    <= low_voltage_entry_enable_in || master_clear_reset_cfg_in;
		end
	end

	assign mem_write_valid_out           = mem_valid;
	assign mem_write_data_out            = mem_word;
	// Serial clock stops after exit, so the pins end the mode on this side
	assign program_mode_out              = prog_s && (mlp_s || hvp_s) && !reset_in;
	assign hv_session_out                = hv_session;
	assign low_voltage_clear_out         = lv_clear;
	assign master_clear_reset_enable_out = mrst_en;
endmodule // spe_device

// ### spe_programmer.sv
// Programmer end: makes the serial clock, runs entry and word transfers
`timescale 1ns/1ps
module spe_programmer (
	// Clock and reset
	input  wire logic   clk_in,
	input  wire logic   reset_in,
	// Commands
	input  wire logic   entry_hv_in,
	input  wire logic   entry_lv_in,
	input  wire logic   exit_in,
	input  wire logic   clear_lv_in,
	input  wire logic   verify_in,
	output logic        cmd_ready_out,
	output logic        session_out,
	// Words to write
	input  wire logic   wr_valid_in,
	input  wire logic [15:0] wr_data_in,
	output logic        wr_ready_out,
	// Verify result
	output logic        verify_valid_out,
	output logic [15:0] verify_data_out,
	// Link pins
	spe_link_if.host    link
);
	typedef enum logic [6:0] {
		SH_IDLE  = 7'b0000001,
		SH_PRE   = 7'b0000010,
		SH_ENTER = 7'b0000100,
		SH_DUMMY = 7'b0001000,
		SH_KEY   = 7'b0010000,
		SH_READY = 7'b0100000,
		SH_XFER  = 7'b1000000
	} spe_host_state_e;

	spe_host_state_e state, next_state;
	logic [2:0]      phase, next_phase;
	logic            sclk, next_sclk;
	logic [5:0]      cnt, next_cnt;
	logic            lv_mode, next_lv_mode;
	logic [31:0]     sreg, next_sreg;
	logic [1:0]      op, next_op;
	logic [15:0]     rd_sr, next_rd_sr;
	logic            mcl_low, next_mcl_low;
	logic            hv, next_hv;
	logic            dout, next_dout;
	logic            doe_n, next_doe_n;
	logic [15:0]     vdata, next_vdata;
	logic            vvalid, next_vvalid;
	logic            dat_m, dat_s;
	logic            tick, rise, fall, pop_now;
	logic            fifo_valid;
	logic [15:0]     fifo_data;

	spe_fifo #(.WIDTH(spe_pkg::WORD_BITS), .DEPTH(spe_pkg::FIFO_DEPTH)) u_fifo (
		.clk_in        (clk_in),
		.reset_in      (reset_in),
		.in_valid_in   (wr_valid_in),
		.in_data_in    (wr_data_in),
		.in_ready_out  (wr_ready_out),
		.out_valid_out (fifo_valid),
		.out_data_out  (fifo_data),
		.out_ready_in  (pop_now)
	);

	assign tick = phase == spe_pkg::SCLK_HALF_LAST;
	assign rise = tick && !sclk;
	assign fall = tick && sclk;

	always_comb begin
		next_state = state; next_cnt = cnt; next_lv_mode = lv_mode;
		next_sreg = sreg; next_op = op; next_rd_sr = rd_sr;
		next_mcl_low = mcl_low; next_hv = hv; next_dout = dout;
		next_doe_n = doe_n; next_vdata = vdata; next_vvalid = 1'b0;
		pop_now = 1'b0;
		// Clock toggles only in the pre-entry, dummy, key and transfer states
		if (state inside {SH_PRE, SH_DUMMY, SH_KEY, SH_XFER}) begin
			next_phase = tick ? 3'h0 : phase + 3'h1;
			next_sclk  = tick ? !sclk : sclk;
		end else begin
			next_phase = 3'h0;
			next_sclk  = 1'b0;
		end
		unique case (state)
			SH_IDLE: begin
				if (entry_hv_in || entry_lv_in) begin
					next_lv_mode = entry_lv_in && !entry_hv_in;
					next_state   = SH_PRE;
					next_cnt     = 6'h00;
				end
			end
			SH_PRE: if (fall) begin
				next_cnt = cnt + 6'h01;
				if (cnt == spe_pkg::DUMMY_LAST) begin
					// Clock and data stay low across the pin change
					next_state   = SH_ENTER;
					next_cnt     = 6'h00;
					next_mcl_low = lv_mode;
					next_hv      = !lv_mode;
				end
			end
			SH_ENTER: begin
				next_cnt = cnt + 6'h01;
				if (cnt == spe_pkg::SETTLE_LAST) begin
					next_state = SH_DUMMY;
					next_cnt   = 6'h00;
				end
			end
			SH_DUMMY: if (fall) begin
				next_cnt = cnt + 6'h01;
				if (cnt == spe_pkg::DUMMY_LAST) begin
					next_cnt   = 6'h00;
					next_state = lv_mode ? SH_KEY : SH_READY;
					next_sreg  = spe_pkg::KEY_VALUE;
					next_dout  = lv_mode && spe_pkg::KEY_VALUE[0];
				end
			end
			SH_KEY: if (fall) begin
				next_cnt  = cnt + 6'h01;
				next_sreg = {1'b0, sreg[31:1]};
				next_dout = sreg[1];
				if (cnt == spe_pkg::KEY_LAST) begin
					next_state = SH_READY;
					next_dout  = 1'b0;
				end
			end
			SH_READY: begin
				// Master clear stays put until exit, for either entry
				if (exit_in) begin
					next_state   = SH_IDLE;
					next_mcl_low = 1'b0;
					next_hv      = 1'b0;
				end else if (clear_lv_in || verify_in || fifo_valid) begin
					next_state = SH_XFER;
					next_cnt   = 6'h00;
					next_op    = clear_lv_in ? spe_pkg::OP_CLEAR :
						(verify_in ? spe_pkg::OP_READ : spe_pkg::OP_STATUS);
					next_sreg  = {13'h0000, 16'h0000, 1'b0, next_op};
					next_dout  = next_op[0];
					next_doe_n = 1'b0;
				end
			end
			SH_XFER: begin
				if (rise && cnt > spe_pkg::TURN_CNT) begin
					next_rd_sr = {dat_s, rd_sr[15:1]};
				end
				if (fall && cnt == spe_pkg::XFER_LAST) begin
					next_state = SH_READY;
					next_dout  = 1'b0;
					next_doe_n = 1'b0;
					if (op == spe_pkg::OP_READ) begin
						next_vdata  = rd_sr;
						next_vvalid = 1'b1;
					end
					// Device reports room: the queued word goes at once
					if (op == spe_pkg::OP_STATUS && rd_sr[0] && fifo_valid) begin
						pop_now    = 1'b1;
						next_state = SH_XFER;
						next_cnt   = 6'h00;
						next_op    = spe_pkg::OP_WRITE;
						next_sreg  = {13'h0000, fifo_data, 1'b0, spe_pkg::OP_WRITE};
						next_dout  = spe_pkg::OP_WRITE[0];
					end
				end else if (fall) begin
					next_cnt   = cnt + 6'h01;
					next_sreg  = {1'b0, sreg[31:1]};
					next_dout  = sreg[1];
					next_doe_n = (next_cnt == spe_pkg::TURN_CNT) ||
						(next_cnt > spe_pkg::TURN_CNT && spe_pkg::op_device_drives(op));
				end
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		dat_m <= link.prog_serial_data;
		dat_s <= dat_m;
		if (reset_in) begin
			state <= SH_IDLE; phase <= 3'h0; sclk <= 1'b0; cnt <= 6'h00;
			lv_mode <= 1'b0; sreg <= 32'h0000_0000; op <= 2'h0; rd_sr <= 16'h0000;
			mcl_low <= 1'b0; hv <= 1'b0; dout <= 1'b0; doe_n <= 1'b0;
			vdata <= 16'h0000; vvalid <= 1'b0;
		end else begin
			state <= next_state; phase <= next_phase; sclk <= next_sclk; cnt <= next_cnt;
			lv_mode <= next_lv_mode; sreg <= next_sreg; op <= next_op; rd_sr <= next_rd_sr;
			mcl_low <= next_mcl_low; hv <= next_hv; dout <= next_dout; doe_n <= next_doe_n;
			vdata <= next_vdata; vvalid <= next_vvalid;
		end
	end

	assign link.prog_serial_clock = sclk;
	assign link.master_clear_low  = mcl_low;
	assign link.master_clear_high = hv;
	assign link.host_data         = dout;
	assign link.host_data_oe_n    = doe_n;
	assign cmd_ready_out          = (state == SH_IDLE) || (state == SH_READY);
	assign session_out            = state == SH_READY || state == SH_XFER;
	assign verify_valid_out       = vvalid;
	assign verify_data_out        = vdata;
endmodule // spe_programmer

// ### spe_link_asserts.sv
// Concurrent checks on the programming link pins
`timescale 1ns/1ps
module spe_link_asserts (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Link pins
	input wire logic prog_serial_clock,
	input wire logic master_clear_low,
	input wire logic master_clear_high,
	input wire logic host_data,
	input wire logic host_data_oe_n,
	input wire logic dev_data_oe_n,
	input wire logic prog_serial_data
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);

	hv_entry_quiet_a: assert property (
		$rose(master_clear_high) |-> (!prog_serial_clock && !prog_serial_data) [*6])
		else $error("high entry without quiet clock and data");
	lv_entry_quiet_a: assert property (
		$rose(master_clear_low) |-> (!prog_serial_clock) [*6])
		else $error("low entry without quiet clock");
	pins_exclusive_a: assert property (
		!(master_clear_low && master_clear_high))
		else $error("both master clear levels at once");
	pins_move_idle_a: assert property (
		($changed(master_clear_low) || $changed(master_clear_high)) |-> !prog_serial_clock)
		else $error("master clear moved with clock high");
	sclk_high_half_a: assert property (
		$rose(prog_serial_clock) |-> prog_serial_clock [*4] ##1 !prog_serial_clock)
		else $error("serial clock high phase wrong");
	sclk_low_half_a: assert property (
		$fell(prog_serial_clock) |-> (!prog_serial_clock) [*4])
		else $error("serial clock low phase short");
	one_driver_a: assert property (
		(master_clear_low || master_clear_high) |-> (host_data_oe_n || dev_data_oe_n))
		else $error("both ends drive the data line");
	host_hold_a: assert property (
		($rose(prog_serial_clock) && !host_data_oe_n) |=> $stable(host_data) [*3])
		else $error("host data moved while clock high");
endmodule // spe_link_asserts

// ### serial_programming_entry_tb.sv
// Self-checking bench joining programmer and device over the link
`timescale 1ns/1ps
module serial_programming_entry_tb;
	logic        clk_in    = 1'b0;
	logic        reset_in  = 1'b1;
	logic [4:0]  cmds      = 5'h00;
	logic        wr_valid  = 1'b0;
	logic [15:0] wr_data   = 16'h0000;
	logic        lv_en     = 1'b0;
	logic        mc_cfg    = 1'b0;
	logic        mem_ready = 1'b0;
	logic        cmd_ready, session, wr_ready, vfy_valid, mem_valid;
	logic        prog_mode, hv_sess, lv_clear, mc_rst_en, prog_mode2;
	logic [15:0] vfy_data, mem_data, last_word;
	logic [15:0] sent_q[$];
	int          err_count   = 0;
	int          checks_done = 0;
	int          clr_cnt     = 0;
	int          vfy_cnt     = 0;
	int          n;

	spe_link_if link ();
	spe_link_if link2 ();
	always #20 clk_in = ~clk_in;

	spe_programmer spe_programmer_inst (.clk_in(clk_in), .reset_in(reset_in),
		.entry_hv_in(cmds[0]), .entry_lv_in(cmds[1]), .exit_in(cmds[2]),
		.clear_lv_in(cmds[3]), .verify_in(cmds[4]), .cmd_ready_out(cmd_ready),
		.session_out(session), .wr_valid_in(wr_valid), .wr_data_in(wr_data),
		.wr_ready_out(wr_ready), .verify_valid_out(vfy_valid),
		.verify_data_out(vfy_data), .link(link));
	spe_device spe_device_inst (.link(link), .clk_in(clk_in), .reset_in(reset_in),
		.low_voltage_entry_enable_in(lv_en), .master_clear_reset_cfg_in(mc_cfg),
		.mem_write_valid_out(mem_valid), .mem_write_data_out(mem_data),
		.mem_write_ready_in(mem_ready), .program_mode_out(prog_mode),
		.hv_session_out(hv_sess), .low_voltage_clear_out(lv_clear),
		.master_clear_reset_enable_out(mc_rst_en));
	// Second device fed by a bench driver that can send a wrong key
	spe_device spe_device_inst2 (.link(link2), .clk_in(clk_in), .reset_in(reset_in),
		.low_voltage_entry_enable_in(lv_en), .master_clear_reset_cfg_in(mc_cfg),
		.mem_write_valid_out(), .mem_write_data_out(), .mem_write_ready_in(mem_ready),
		.program_mode_out(prog_mode2), .hv_session_out(), .low_voltage_clear_out(),
		.master_clear_reset_enable_out());
	spe_link_asserts spe_link_asserts_inst (.clk_in(clk_in), .reset_in(reset_in),
		.prog_serial_clock(link.prog_serial_clock), .master_clear_low(link.master_clear_low),
		.master_clear_high(link.master_clear_high), .host_data(link.host_data),
		.host_data_oe_n(link.host_data_oe_n), .dev_data_oe_n(link.dev_data_oe_n),
		.prog_serial_data(link.prog_serial_data));

	always @(posedge clk_in) begin
		if (lv_clear === 1'b1) begin
			clr_cnt <= clr_cnt + 1;
		end
		if (vfy_valid === 1'b1) begin
			vfy_cnt <= vfy_cnt + 1;
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic tick(input int lim);
		n++;
		if (n > lim) begin
			err_count++;
			stop_test();
		end
	endtask

	// Values read right after the edge are the ones the design sampled
	task automatic wait_rdy();
		n = 0;
		do begin
			@(posedge clk_in);
			tick(4000);
		end while (cmd_ready !== 1'b1);
	endtask

	// One-cycle pulse; safe only with the write buffer empty
	task automatic cmd(input int c);
		wait_rdy();
		cmds <= 5'h01 << c;
		@(posedge clk_in);
		cmds <= 5'h00;
		wait_rdy();
		repeat (8) @(posedge clk_in);
	endtask

	task automatic shift(input logic [31:0] k, input int cnt);
		for (int i = 0; i < cnt; i++) begin
			link2.host_data <= k[i];
			repeat (4) @(posedge clk_in);
			link2.prog_serial_clock <= 1'b1;
			repeat (4) @(posedge clk_in);
			link2.prog_serial_clock <= 1'b0;
		end
	endtask

	initial begin
		{link2.prog_serial_clock, link2.master_clear_low, link2.master_clear_high,
			link2.host_data, link2.host_data_oe_n} = 5'h00;
		void'($urandom(32'h2f70_391a));
		repeat (8) @(posedge clk_in);
		reset_in <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_in);
			{lv_en, mc_cfg} <= 2'(i);
			repeat (3) @(posedge clk_in);
			check(16'(mc_rst_en), 16'(lv_en | mc_cfg));
		end
		lv_en <= 1'b0;
		cmd(1);
		check(16'(prog_mode), 16'h0000);
		check(16'({link.master_clear_low, link.master_clear_high}), 16'h0002);
		cmd(2);
		lv_en <= 1'b1;
		cmd(1);
		check(16'(prog_mode), 16'h0001);
		check(16'(session), 16'h0001);
		// Fill the write buffer while memory stalls
		wr_valid <= 1'b1;
		n = 0;
		while (n < 64) begin
			@(posedge clk_in);
			if (wr_ready !== 1'b1) begin
				break;
			end
			sent_q.push_back(wr_data);
			wr_data <= 16'($urandom);
			n++;
		end
		wr_valid <= 1'b0;
		check(16'(n), 16'(spe_pkg::FIFO_DEPTH));
		n = 0;
		while (sent_q.size() > 0) begin
			@(posedge clk_in);
			if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
				last_word = sent_q.pop_front();
				check(mem_data, last_word);
			end
			mem_ready <= 1'($urandom);
			tick(40000);
		end
		mem_ready <= 1'b1;
		cmd(3);
		check(16'(clr_cnt), 16'h0000);
		cmd(4);
		check(vfy_data, last_word);
		check(16'(vfy_cnt), 16'h0001);
		cmd(2);
		check(16'(prog_mode), 16'h0000);
		check(16'({link.master_clear_low, link.master_clear_high,
			link.prog_serial_clock}), 16'h0000);
		cmd(0);
		check(16'({hv_sess, link.master_clear_low, link.master_clear_high}), 16'h0005);
		cmd(3);
		check(16'(clr_cnt), 16'h0001);
		cmd(2);
		check(16'(hv_sess), 16'h0000);
		// Released clocks reset the far link side first
		shift(32'h0000_0000, 4);
		link2.master_clear_low <= 1'b1;
		repeat (8) @(posedge clk_in);
		shift(~spe_pkg::KEY_VALUE, 32);
		repeat (8) @(posedge clk_in);
		check(16'(prog_mode2), 16'h0000);
		shift(spe_pkg::KEY_VALUE, 32);
		repeat (8) @(posedge clk_in);
		check(16'(prog_mode2), 16'h0001);
		stop_test();
	end
endmodule // serial_programming_entry_tb
